// file: fpic_regs.svh
`ifndef FPIC_REGS_SVH
`define FPIC_REGS_SVH
// ------------------------------------------------------------
// timing counts, in clock cycles
// ------------------------------------------------------------
`define FPIC_LAT_SIMPLE      4'h4
`define FPIC_LAT_CONVERT     4'h8
`define FPIC_LAT_MAC_SP      4'h8
`define FPIC_LAT_MAC_DP      4'h9
`define FPIC_THR_MAC_DP      4'h2
`define FPIC_LAT_LDM_EXTRA   4'h3
`define FPIC_LAT_XFER        4'h4
`define FPIC_LAT_XFER_OUT    4'h2
`define FPIC_DS_ITER_SP      5'h0E
`define FPIC_DS_ITER_DP      5'h1C
// ------------------------------------------------------------
// field encodings
// ------------------------------------------------------------
`define FPIC_VLEN_W          3
`define FPIC_STRIDE_W        2
`define FPIC_BANK_W          2
`define FPIC_SCALAR_BANK     2'h0
`endif

// file: fpic_pkg.sv
package fpic_pkg;
  // arithmetic operation classes
  typedef enum logic [2:0] {
    FPIC_OP_SIMPLE  = 3'h0,  // absolute value, negate, precision convert, copy
    FPIC_OP_CONVERT = 3'h1,  // integer <-> float
    FPIC_OP_MAC     = 3'h2,  // add, multiply, multiply-accumulate family
    FPIC_OP_DIVSQRT = 3'h3   // divide or square root
  } fpic_op_e;
  // transfer classes
  typedef enum logic [2:0] {
    FPIC_XF_SINGLE   = 3'h0, // single load or store
    FPIC_XF_MULTIPLE = 3'h1, // load or store multiple
    FPIC_XF_PAIR_IN  = 3'h2, // paired single move in / double move in
    FPIC_XF_PAIR_OUT = 3'h3, // paired single move out / double move out
    FPIC_XF_SYS_WR   = 3'h4, // system register write
    FPIC_XF_SYS_RD   = 3'h5  // system register read
  } fpic_xfer_e;
  // divide/sqrt pipe states, one-hot
  typedef enum logic [2:0] {
    FPIC_DS_IDLE   = 3'b001,
    FPIC_DS_SHARED = 3'b010,
    FPIC_DS_ITER   = 3'b100
  } fpic_ds_state_e;
endpackage

// file: fpic_issue_ctrl.sv
`timescale 1ns/10ps
`include "fpic_regs.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module fpic_issue_ctrl #(
  parameter int CNT_W = 6  // width of the occupancy counters
) (
  // clock, reset, enable
  input  wire logic                      sys_clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      clk_en_in,
  // vector control fields
  input  wire logic [`FPIC_VLEN_W-1:0]   vector_length_field_in,
  input  wire logic [`FPIC_STRIDE_W-1:0] vector_stride_field_in,
  // arithmetic request
  input  wire logic                      arith_req_in,
  input  wire fpic_pkg::fpic_op_e        arith_op_in,
  input  wire logic                      arith_dp_in,
  input  wire logic [`FPIC_BANK_W-1:0]   arith_dest_bank_in,
  input  wire logic                      arith_hazard_in,
  // transfer request
  input  wire logic                      xfer_req_in,
  input  wire fpic_pkg::fpic_xfer_e      xfer_kind_in,
  input  wire logic                      xfer_dp_in,
  input  wire logic [4:0]                xfer_words_in,
  input  wire logic                      xfer_hazard_in,
  input  wire logic                      host_stall_in,
  // issue answers
  output logic                           arith_issue_out,
  output logic                           ds_issue_out,
  output logic                           xfer_issue_out,
  // timing of the last issued operations
  output logic [3:0]                     arith_latency_out,
  output logic [3:0]                     xfer_latency_out,
  output logic [1:0]                     xfer_beats_out,
  output logic [CNT_W-1:0]               xfer_cycles_out,
  output logic [1:0]                     vector_stride_out,
  // pipe status
  output logic                           mac_busy_out,
  output logic                           ds_busy_out,
  output logic                           ls_busy_out
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // the dp divide reload needs five bits, plus headroom for the counters
  if (CNT_W < 6) begin
    $error("CNT_W too small for the longest divide");
  end

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  // iteration count: field value plus one, bank 0 forces one
  function automatic logic [3:0] iter_count(input logic [2:0] len, input logic [1:0] bank);
    iter_count = (bank == `FPIC_SCALAR_BANK) ? 4'h1 : ({1'b0, len} + 4'h1);
  endfunction

  // result latency per class, forwarding taking one off
  function automatic logic [3:0] op_latency(input fpic_pkg::fpic_op_e op, input logic dp);
    logic [3:0] raw;
    raw = `FPIC_LAT_SIMPLE;
    case (op)
      fpic_pkg::FPIC_OP_SIMPLE:  raw = `FPIC_LAT_SIMPLE;
      fpic_pkg::FPIC_OP_CONVERT: raw = `FPIC_LAT_CONVERT;
      fpic_pkg::FPIC_OP_MAC:     raw = dp ? `FPIC_LAT_MAC_DP : `FPIC_LAT_MAC_SP;
      default:                   raw = 4'hF;                          // divide: long, tracked by ds pipe
    endcase
    op_latency = raw - 4'h1;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [3:0]                  mac_iter_r;     // unissued mac vector iterations
  logic                        dp_mul_r;       // dp multiply in its first multiply cycle
  logic [3:0]                  ds_iter_r;      // unissued divide iterations
  logic [CNT_W-1:0]            ds_cnt_r;       // cycles left in current divide iteration
  logic [CNT_W-1:0]            ds_reload_r;    // per-iteration length of current divide
  fpic_pkg::fpic_ds_state_e    ds_state_r;     // divide pipe state
  logic [CNT_W-1:0]            ls_cnt_r;       // remaining multiple-transfer cycles
  logic                        serial_r;       // system register move draining

  // combinational helpers, recomputed from the registers and inputs each cycle
  logic                        arith_is_ds;    // request is a divide or square root
  logic                        mac_free;       // mac first stage can take an operation
  logic                        vec_pending;    // vector iterations still to issue
  logic                        ds_shared_now;  // divide holds the shared first stage
  logic [3:0]                  new_iters;      // iterations of the requested operation
  logic [4:0]                  xfer_x;         // cycles of a multiple transfer

  assign arith_is_ds = (arith_op_in == fpic_pkg::FPIC_OP_DIVSQRT);
  assign new_iters   = iter_count(vector_length_field_in, arith_dest_bank_in);
  assign ds_shared_now = (ds_state_r == fpic_pkg::FPIC_DS_SHARED);
  // vector iterations still unissued in either arithmetic pipe
  assign vec_pending = (mac_iter_r > 4'h1) || (ds_iter_r != 4'h0);
  // the divide's shared first cycle also takes the mac first stage
  assign mac_free    = (mac_iter_r <= 4'h1) && !dp_mul_r && !ds_shared_now;

  // ------------------------------------------------------------
  // issue decisions, recomputed every cycle, one per pipe
  // ------------------------------------------------------------
  // pipes are judged separately, but mac and divide block each other and a system move blocks all
  always_comb begin
    // a refused request is not remembered: the host must hold it
    arith_issue_out = arith_req_in && !arith_is_ds && !arith_hazard_in && !serial_r
                      && mac_free && !vec_pending;
    // divides also wait out a serializing move
    ds_issue_out    = arith_req_in && arith_is_ds && !arith_hazard_in && !serial_r
                      && (ds_state_r == fpic_pkg::FPIC_DS_IDLE)
                      && (mac_iter_r <= 4'h1) && !ds_shared_now;
    // transfer needs no hazard, no host stall, no multiple in flight
    xfer_issue_out  = xfer_req_in && !xfer_hazard_in && !host_stall_in
                      && (ls_cnt_r == '0) && !serial_r;
  end

  // load/store multiple beat count: N/2 even, N/2+1 odd
  assign xfer_x = (xfer_words_in >> 1) + {4'h0, xfer_words_in[0]};

  // ------------------------------------------------------------
  // multiply-accumulate pipe occupancy
  // ------------------------------------------------------------
  // a vector op holds the first stage one cycle per iteration
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // reset leaves the pipe empty and free
      mac_iter_r <= 4'h0;
      dp_mul_r   <= 1'b0;
    end else if (clk_en_in) begin
      // clock enable low freezes the counts, so no cycle is lost
      if (arith_issue_out) begin
        // issue only happens with at most one iteration left, so overwriting is safe
        mac_iter_r <= new_iters;
        // dp multiply family blocks next cycle: throughput 2
        dp_mul_r   <= arith_dp_in && (arith_op_in == fpic_pkg::FPIC_OP_MAC);
      end else begin
        // one iteration leaves the first stage every cycle
        if (mac_iter_r != 4'h0) begin
          mac_iter_r <= mac_iter_r - 4'h1;
        end
        // the dp multiply gap lasts a single cycle
        dp_mul_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // divide/sqrt pipe state machine
  // ------------------------------------------------------------
  // each iteration: one shared cycle, then iterates alone
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // reset parks the divide pipe idle with no iterations owed
      ds_state_r  <= fpic_pkg::FPIC_DS_IDLE;
      ds_iter_r   <= 4'h0;
      ds_cnt_r    <= '0;
      ds_reload_r <= '0;
    end else if (clk_en_in) begin
      case (ds_state_r)
        fpic_pkg::FPIC_DS_IDLE: begin
          // a divide taken now owns the shared first stage next cycle
          if (ds_issue_out) begin
            ds_state_r  <= fpic_pkg::FPIC_DS_SHARED;
            // the first iteration is under way, so only the rest are counted
            ds_iter_r   <= new_iters - 4'h1;
            // the reload makes every vector iteration as long as the first
            ds_reload_r <= CNT_W'(arith_dp_in ? `FPIC_DS_ITER_DP : `FPIC_DS_ITER_SP);
            ds_cnt_r    <= CNT_W'(arith_dp_in ? `FPIC_DS_ITER_DP : `FPIC_DS_ITER_SP);
          end
        end
        fpic_pkg::FPIC_DS_SHARED: begin
          // the shared stage is held for exactly one cycle
          ds_state_r <= fpic_pkg::FPIC_DS_ITER;
        end
        fpic_pkg::FPIC_DS_ITER: begin
          if (ds_cnt_r > CNT_W'(1)) begin
            // still iterating alone in the divide stages
            ds_cnt_r <= ds_cnt_r - CNT_W'(1);
          end else if (ds_iter_r != 4'h0) begin
            // next vector iteration needs the shared stage again
            ds_iter_r  <= ds_iter_r - 4'h1;
            ds_cnt_r   <= ds_reload_r;
            ds_state_r <= fpic_pkg::FPIC_DS_SHARED;
          end else begin
            // last iteration done, a new divide may start next cycle
            ds_state_r <= fpic_pkg::FPIC_DS_IDLE;
          end
        end
        default: begin
          // an illegal code recovers to idle rather than locking the pipe
          ds_state_r <= fpic_pkg::FPIC_DS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // load/store pipe and serialization
  // ------------------------------------------------------------
  // counts assume data from cache / accepted at once; host_stall covers the rest
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // reset drops any multiple in flight and any pending serialization
      ls_cnt_r <= '0;
      serial_r <= 1'b0;
    end else if (clk_en_in) begin
      // the issue cycle is the first beat, so one less is left to count
      if (xfer_issue_out && (xfer_kind_in == fpic_pkg::FPIC_XF_MULTIPLE) && (xfer_x > 5'h1)) begin
        ls_cnt_r <= CNT_W'(xfer_x - 5'h1);
      end else if ((ls_cnt_r != '0) && !host_stall_in) begin
        // a stalled host holds the beat count where it is
        ls_cnt_r <= ls_cnt_r - CNT_W'(1);
      end
      // a system move sets serial_r, so later issues wait for all pipes to drain
      if (xfer_issue_out && ((xfer_kind_in == fpic_pkg::FPIC_XF_SYS_WR) ||
                             (xfer_kind_in == fpic_pkg::FPIC_XF_SYS_RD))) begin
        serial_r <= 1'b1;
      end else if ((mac_iter_r == 4'h0) && (ds_state_r == fpic_pkg::FPIC_DS_IDLE)
                   && (ls_cnt_r == '0)) begin
        // released only once all three pipes are empty
        serial_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // registered timing answers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // reset clears every timing answer
      arith_latency_out <= 4'h0;
      xfer_latency_out  <= 4'h0;
      xfer_beats_out    <= 2'h0;
      xfer_cycles_out   <= '0;
      vector_stride_out <= 2'h0;
    end else if (clk_en_in) begin
      if (arith_issue_out) begin
        // divides answer through the ds pipe and leave these untouched
        arith_latency_out <= op_latency(arith_op_in, arith_dp_in);
        vector_stride_out <= vector_stride_field_in + 2'h1;
      end
      if (xfer_issue_out) begin
        case (xfer_kind_in)
          fpic_pkg::FPIC_XF_MULTIPLE: begin
            // latency fits four bits only up to 13 beats; longer ones wrap
            xfer_cycles_out  <= CNT_W'(xfer_x);
            xfer_latency_out <= 4'(xfer_x[3:0] + `FPIC_LAT_LDM_EXTRA - 4'h1);
            xfer_beats_out   <= 2'h1;
          end
          fpic_pkg::FPIC_XF_PAIR_IN: begin
            // moves in reach the register file like a single load
            xfer_cycles_out  <= CNT_W'(1);
            xfer_latency_out <= `FPIC_LAT_XFER - 4'h1;
            xfer_beats_out   <= xfer_dp_in ? 2'h1 : 2'h2;
          end
          fpic_pkg::FPIC_XF_PAIR_OUT: begin
            // moves out only wait for the read port
            xfer_cycles_out  <= CNT_W'(1);
            xfer_latency_out <= `FPIC_LAT_XFER_OUT - 4'h1;
            xfer_beats_out   <= xfer_dp_in ? 2'h1 : 2'h2;
          end
          fpic_pkg::FPIC_XF_SYS_RD: begin
            // a system register read answers like a move out
            xfer_cycles_out  <= CNT_W'(1);
            xfer_latency_out <= `FPIC_LAT_XFER_OUT - 4'h1;
            xfer_beats_out   <= 2'h1;
          end
          default: begin
            // single transfers and system register writes
            xfer_cycles_out  <= CNT_W'(1);
            xfer_latency_out <= `FPIC_LAT_XFER - 4'h1;
            xfer_beats_out   <= 2'h1;
          end
        endcase
      end
    end
  end

  // busy flags for the outside
  // mac busy is the inverse of mac_free, only one term of the arith issue condition
  assign mac_busy_out = !mac_free;
  assign ds_busy_out  = (ds_state_r != fpic_pkg::FPIC_DS_IDLE);
  assign ls_busy_out  = (ls_cnt_r != '0) || serial_r;

endmodule

// file: fpic_host.sv
`timescale 1ns/10ps
module fpic_host (
  // clock and taken transfers
  input  wire logic       sys_clk_in,
  input  wire logic       xfer_issue_in,
  // how long the host needs per transfer, 0 when data is at hand
  input  wire logic [3:0] stall_len_in,
  output logic            host_stall_out
);
  logic       seen_r = 1'b0; // a transfer was taken at the last edge
  logic [3:0] left_r = 4'h0; // stall cycles still owed
  initial host_stall_out = 1'b0;
  always @(posedge sys_clk_in) seen_r <= xfer_issue_in;
  // cached data answers at once; a miss stalls the pipe for a while
  always @(negedge sys_clk_in) begin
    if (seen_r) left_r = stall_len_in;
    host_stall_out <= (left_r != 4'h0);
    if (left_r != 4'h0) left_r = left_r - 4'h1;
  end
endmodule

// file: fpic_chk.sv
`timescale 1ns/10ps
module fpic_chk #(
  parameter int CNT_W = 6  // width of the occupancy counters
) (
  // clock, reset, requests
  input wire logic sys_clk_in, srst_in, clk_en_in, arith_req_in, arith_dp_in, arith_hazard_in,
  input wire logic [2:0] vector_length_field_in,
  input wire logic [1:0] arith_dest_bank_in,
  input wire fpic_pkg::fpic_op_e arith_op_in,
  input wire fpic_pkg::fpic_xfer_e xfer_kind_in,
  input wire logic xfer_req_in, xfer_dp_in, xfer_hazard_in, host_stall_in,
  input wire logic [4:0] xfer_words_in,
  // answers
  input wire logic arith_issue_out, ds_issue_out, xfer_issue_out,
  input wire logic [3:0] arith_latency_out,
  input wire logic [1:0] xfer_beats_out,
  input wire logic [CNT_W-1:0] xfer_cycles_out
);
  // ----------------------------------------
  // issue and timing checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  AST_ARITH_CAUSE: assert property (arith_issue_out |-> arith_req_in && !arith_hazard_in)
    else $error("arith issue without clean request");
  AST_DS_CAUSE: assert property (ds_issue_out |-> arith_req_in && !arith_hazard_in)
    else $error("divide issue without clean request");
  AST_XFER_CAUSE: assert property (xfer_issue_out |-> xfer_req_in && !xfer_hazard_in && !host_stall_in)
    else $error("transfer issue while blocked");
  AST_ONE_START: assert property (!(arith_issue_out && ds_issue_out))
    else $error("two starts on one request");
  AST_DS_GAP: assert property (ds_issue_out && clk_en_in |=> !ds_issue_out [*8] ##1 !ds_issue_out [*6])
    else $error("divide restarted too soon");
  AST_DP_GAP: assert property (arith_issue_out && clk_en_in && arith_dp_in &&
    arith_op_in == fpic_pkg::FPIC_OP_MAC |=> !arith_issue_out) else $error("double multiply not spaced");
  AST_VEC_HOLD: assert property (arith_issue_out && clk_en_in && arith_op_in == fpic_pkg::FPIC_OP_MAC &&
    arith_dest_bank_in != 2'h0 && vector_length_field_in == 3'h3 |=> !arith_issue_out [*3])
    else $error("vector add released early");
  AST_LAT: assert property (arith_issue_out && clk_en_in |=> arith_latency_out ==
    ($past(arith_op_in) == fpic_pkg::FPIC_OP_SIMPLE ? 4'h3 :
     $past(arith_op_in) == fpic_pkg::FPIC_OP_MAC && $past(arith_dp_in) ? 4'h8 : 4'h7))
    else $error("arith latency wrong");
  AST_BEATS: assert property (xfer_issue_out && clk_en_in &&
    (xfer_kind_in == fpic_pkg::FPIC_XF_PAIR_IN || xfer_kind_in == fpic_pkg::FPIC_XF_PAIR_OUT) |=>
    xfer_beats_out == ($past(xfer_dp_in) ? 2'h1 : 2'h2)) else $error("pair beats wrong");
  AST_LDM: assert property (xfer_issue_out && clk_en_in && xfer_kind_in == fpic_pkg::FPIC_XF_MULTIPLE |=>
    xfer_cycles_out == CNT_W'(({1'b0, $past(xfer_words_in)} + 6'h01) >> 1))
    else $error("multiple cycle count wrong");
  COV_VEC: cover property (arith_issue_out && vector_length_field_in == 3'h3 && arith_dest_bank_in != 2'h0);
  COV_DS_DP: cover property (ds_issue_out && arith_dp_in);
  COV_LDM: cover property (xfer_issue_out && xfer_kind_in == fpic_pkg::FPIC_XF_MULTIPLE);
endmodule
bind fpic_issue_ctrl fpic_chk #(.CNT_W(CNT_W)) chk_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .clk_en_in(clk_en_in), .arith_req_in(arith_req_in), .arith_dp_in(arith_dp_in), .arith_hazard_in(arith_hazard_in),
  .vector_length_field_in(vector_length_field_in), .arith_dest_bank_in(arith_dest_bank_in),
  .arith_op_in(arith_op_in), .xfer_kind_in(xfer_kind_in), .xfer_req_in(xfer_req_in), .xfer_dp_in(xfer_dp_in),
  .xfer_hazard_in(xfer_hazard_in), .host_stall_in(host_stall_in), .xfer_words_in(xfer_words_in),
  .arith_issue_out(arith_issue_out), .ds_issue_out(ds_issue_out), .xfer_issue_out(xfer_issue_out),
  .arith_latency_out(arith_latency_out), .xfer_beats_out(xfer_beats_out), .xfer_cycles_out(xfer_cycles_out));

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // stimulus and design
  // ----------------------------------------
  typedef struct packed {
    logic x; logic [2:0] c; logic dp; logic [1:0] b; logic [2:0] l; logic [4:0] w;
    logic [7:0] g; logic [7:0] lt;  // issue spacing (0 unchecked), forwarded latency
  } fpic_row_s;
  localparam fpic_row_s ROWS [14] = '{
    '{1'h0,3'h0,1'h0,2'h1,3'h0,5'h00,8'h01,8'h03}, '{1'h0,3'h0,1'h1,2'h1,3'h0,5'h00,8'h01,8'h03},
    '{1'h0,3'h1,1'h0,2'h1,3'h0,5'h00,8'h01,8'h07}, '{1'h0,3'h2,1'h0,2'h1,3'h0,5'h00,8'h01,8'h07},
    '{1'h0,3'h2,1'h1,2'h1,3'h0,5'h00,8'h02,8'h08}, '{1'h0,3'h2,1'h0,2'h1,3'h3,5'h00,8'h04,8'h07},
    '{1'h0,3'h2,1'h0,2'h0,3'h3,5'h00,8'h01,8'h07}, '{1'h0,3'h3,1'h0,2'h0,3'h0,5'h00,8'h10,8'h00},
    '{1'h0,3'h3,1'h1,2'h0,3'h0,5'h00,8'h1E,8'h00}, '{1'h1,3'h0,1'h0,2'h0,3'h0,5'h01,8'h01,8'h03},
    '{1'h1,3'h1,1'h0,2'h0,3'h0,5'h05,8'h03,8'h05}, '{1'h1,3'h1,1'h0,2'h0,3'h0,5'h04,8'h02,8'h04},
    '{1'h1,3'h2,1'h0,2'h0,3'h0,5'h02,8'h01,8'h03}, '{1'h1,3'h5,1'h0,2'h0,3'h0,5'h01,8'h00,8'h01}};
  logic sys_clk_in = 1'b0, srst_in = 1'b1, clk_en_in = 1'b1, arith_req_in = 1'b0, arith_dp_in = 1'b0;
  logic arith_hazard_in = 1'b0, xfer_req_in = 1'b0, xfer_dp_in = 1'b0, xfer_hazard_in = 1'b0;
  logic [2:0] vector_length_field_in = 3'h0;
  logic [1:0] vector_stride_field_in = 2'h0, arith_dest_bank_in = 2'h0, xfer_beats_out, vector_stride_out;
  logic [4:0] xfer_words_in = 5'h00;
  logic [3:0] stall_len = 4'h0, arith_latency_out, xfer_latency_out;
  logic [5:0] xfer_cycles_out;
  logic arith_issue_out, ds_issue_out, xfer_issue_out, mac_busy_out, ds_busy_out, ls_busy_out, host_stall_in;
  fpic_pkg::fpic_op_e arith_op_in = fpic_pkg::FPIC_OP_SIMPLE;
  fpic_pkg::fpic_xfer_e xfer_kind_in = fpic_pkg::FPIC_XF_SINGLE;
  int failures = 0, check_count = 0, n;
  fpic_row_s r;
  always #20 sys_clk_in = ~sys_clk_in;
  fpic_issue_ctrl #(.CNT_W(6)) dut_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .vector_length_field_in(vector_length_field_in), .vector_stride_field_in(vector_stride_field_in),
    .arith_req_in(arith_req_in), .arith_op_in(arith_op_in), .arith_dp_in(arith_dp_in),
    .arith_dest_bank_in(arith_dest_bank_in), .arith_hazard_in(arith_hazard_in), .xfer_req_in(xfer_req_in),
    .xfer_kind_in(xfer_kind_in), .xfer_dp_in(xfer_dp_in), .xfer_words_in(xfer_words_in),
    .xfer_hazard_in(xfer_hazard_in), .host_stall_in(host_stall_in), .arith_issue_out(arith_issue_out),
    .ds_issue_out(ds_issue_out), .xfer_issue_out(xfer_issue_out), .arith_latency_out(arith_latency_out),
    .xfer_latency_out(xfer_latency_out), .xfer_beats_out(xfer_beats_out), .xfer_cycles_out(xfer_cycles_out),
    .vector_stride_out(vector_stride_out), .mac_busy_out(mac_busy_out), .ds_busy_out(ds_busy_out),
    .ls_busy_out(ls_busy_out));
  fpic_host host_u (.sys_clk_in(sys_clk_in), .xfer_issue_in(xfer_issue_out), .stall_len_in(stall_len),
    .host_stall_out(host_stall_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // waits, bounded, until the chosen issue output is seen before an edge
  task wait_hit(input int s, output int k);
    k = 0;
    while (k < 100 && (s == 0 ? arith_issue_out : s == 1 ? ds_issue_out : xfer_issue_out) !== 1'b1) begin
      @(negedge sys_clk_in);
      #1;
      k++;
    end
  endtask
  // drops every request and lets all three pipes drain
  task idle;
    @(negedge sys_clk_in);
    {arith_req_in, xfer_req_in, arith_hazard_in, xfer_hazard_in} = 4'h0;
    repeat (100) if (mac_busy_out | ds_busy_out | ls_busy_out) @(negedge sys_clk_in);
  endtask
  task set_req(input fpic_row_s q);
    @(negedge sys_clk_in);
    arith_op_in = fpic_pkg::fpic_op_e'(q.c);
    xfer_kind_in = fpic_pkg::fpic_xfer_e'(q.c);
    {arith_dp_in, xfer_dp_in, arith_dest_bank_in, vector_length_field_in} = {q.dp, q.dp, q.b, q.l};
    xfer_words_in = q.w;
    {arith_req_in, xfer_req_in} = {!q.x, q.x};
    #1;
  endtask
  // holds one request until it is taken, and until it is taken again when g is nonzero: checks latency except for divides, and issue spacing when g is nonzero
  task run_row(input fpic_row_s q);
    int s, k;
    s = q.x ? 2 : (q.c == 3'h3 ? 1 : 0);
    set_req(q);
    wait_hit(s, k);
    @(negedge sys_clk_in);
    if (s != 1) check(q.x ? xfer_latency_out : arith_latency_out, q.lt);
    #1;
    if (q.g != 8'h00) wait_hit(s, k);
    if (q.g != 8'h00) check(8'(k + 1), q.g);
    idle();
  endtask
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge sys_clk_in);
    srst_in = 1'b0;
    foreach (ROWS[i]) run_row(ROWS[i]);
    r = ROWS[10];
    r.g = 8'h05;
    stall_len = 4'h2;
    run_row(r);  // slow host stretches the multiple transfer
    stall_len = 4'h0;
    check(xfer_cycles_out, 8'h03);
    r = ROWS[12];
    run_row(r);
    check(xfer_beats_out, 8'h02);
    r.dp = 1'b1;
    run_row(r);
    check(xfer_beats_out, 8'h01);
    set_req(ROWS[5]);  // vector add, then divide and a pair move out beside it
    wait_hit(0, n);
    r = ROWS[9];
    r.c = 3'h3;
    r.b = 2'h1;
    set_req(r);
    arith_req_in = 1'b1;
    #1;
    check(ds_issue_out, 8'h00);
    check(xfer_issue_out, 8'h01);
    check(vector_stride_out, 8'h01);
    check(mac_busy_out, 8'h01);
    idle();
    r = ROWS[7];  // two-iteration vector divide, then an add
    r.b = 2'h1;
    r.l = 3'h1;
    set_req(r);
    wait_hit(1, n);
    @(negedge sys_clk_in);
    arith_op_in = fpic_pkg::FPIC_OP_MAC;
    #1;
    check(ds_busy_out, 8'h01);
    check(mac_busy_out, 8'h01);
    wait_hit(0, n);
    check(8'(n > 13 && n < 17), 8'h01);
    idle();
    set_req(ROWS[3]);
    {arith_hazard_in, xfer_hazard_in, xfer_req_in} = 3'h7;
    #1;
    check(arith_issue_out, 8'h00);
    check(xfer_issue_out, 8'h00);
    idle();
    set_req(ROWS[10]);  // multiple transfer frozen while the clock enable is low
    wait_hit(2, n);
    @(negedge sys_clk_in);
    clk_en_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check(ls_busy_out, 8'h01);
    clk_en_in = 1'b1;
    #1;
    wait_hit(2, n);
    check(8'(n), 8'h02);
    idle();
    @(negedge sys_clk_in);
    srst_in = 1'b1;
    @(negedge sys_clk_in);
    srst_in = 1'b0;
    check({arith_latency_out, xfer_latency_out}, 8'h00);
    stop_test();
  end
endmodule
